// [src/dbm_debug_module.sv]
`timescale 1ns/10ps
// Functional notes
// - jtag lets host halt, resume, read and write cpu registers and memory
// - code downloaded over jtag is written into processor memory
// - software breakpoint instructions in ram halt the processor
// - hardware breakpoint halts on instruction address, for flash code
// - data trigger matches address, data value, or read/write direction
// - trigger action halts cpu, starts trace, or pulses trigger output
// - two triggers combine into an address or data range trigger
// - instruction trace records executed instruction addresses in real time
// - data trace records address and data of every load and store on chip, and of those in the low trace clock phase off chip
// - on-chip trace stores frames in an internal buffer
// - off-chip trace streams frames with a generated trace clock to probe
// - external request suspends cpu, acknowledge answers it
// - trace buffer depth buildable from 128 to 64k frames
module dbm_debug_module #(
  parameter int TRACE_FRAMES = dbm_pkg::TRACE_DEPTH
) (
  input  wire logic                      clk_sys,
  input  wire logic                      srst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [dbm_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      jtagTck,
  input  wire logic                      jtagTms,
  input  wire logic                      jtagTdi,
  output logic                           jtagTdo,
  output logic                           cpuHaltReq,
  input  wire logic                      cpuHalted,
  input  wire logic                      swBreak,
  input  wire logic                      instValid,
  input  wire logic [31:0]               instAddr,
  input  wire logic                      dValid,
  input  wire logic                      dWrite,
  input  wire logic [31:0]               dAddr,
  input  wire logic [31:0]               dData,
  output logic                           memReq,
  output logic                           memWrite,
  output logic                           memSpace,
  output logic      [31:0]               memAddr,
  output logic      [31:0]               memWdata,
  input  wire logic [31:0]               memRdata,
  input  wire logic                      memAck,
  output logic                           trigOut,
  output logic                           traceClkOut,
  output logic                           traceStrobe,
  output logic      [dbm_pkg::TF_W-1:0]  traceFrameOut,
  input  wire logic                      dbgReq,
  output logic                           dbgAck,
  output logic                           irq
);
  import dbm_pkg::*;
  localparam int TIW = $clog2(TRACE_FRAMES);

  logic [3:0]        syn1_q, syn2_q, syn3_q;
  logic              halt_q, halt_d, halted_q, tdo_q, trigOut_q, trigOut_d;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [31:0]       hwBp_q, hwBp_d, memAddr_q, memAddr_d, memWdata_q, memWdata_d;
  logic [31:0]       memRd_q, memRd_d, prdata_q, prdata_d, rdata;
  logic [31:0]       tAddr_q [2], tAddr_d [2], tData_q [2], tData_d [2];
  logic [CFG_W-1:0]  tCfg_q [2], tCfg_d [2];
  logic [EV_W-1:0]   stat_q, stat_d, inten_q, inten_d, ev, statClr;
  logic              memReq_q, memReq_d, memWrite_q, memWrite_d, memSpace_q, memSpace_d;
  logic [JT_LEN-1:0] jsr_q, jsr_d;
  logic [7:0]        jtOp;
  logic              tckRise, tmsRise, tmsFall, jtExec, jtMem, wrAcc, rdSetup;
  logic              haltSet, haltClr, bpHit, hitRange, actHalt, actTrace, actOut;
  logic [1:0]        hitOne, fire;
  logic [TIW-1:0]    wp_q, wp_d, tIdx_q, tIdx_d;
  logic [TF_W-1:0]   tbuf_q [TRACE_FRAMES], frame, tEnt, traceFrame_q, traceFrame_d;
  logic              tWe, traceHit, traceLoss, traceClk_q, traceClk_d, traceStrobe_q, traceStrobe_d;

  // trigger match: direction must be enabled, every enabled compare must hold
  function automatic logic trig_hit(input logic [CFG_W-1:0] cfg, input logic aOk, input logic dOk);
    trig_hit = dValid & (dWrite ? cfg[CFG_WR] : cfg[CFG_RD])
             & (~cfg[CFG_ADDR] | aOk) & (~cfg[CFG_DATA] | dOk);
  endfunction : trig_hit

  // word aligned, inside the plain block or a trigger slot
  function automatic logic addr_ok(input logic [APB_AW-1:0] a);
    addr_ok = (a[1:0] == 2'b00) && ((a <= ADDR_TDDATA) || (a[7:5] == TRIG_SEL && a[3:2] != 2'b11));
  endfunction : addr_ok

  // two-flop sync of link pins and request; third stage only for edges
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      syn1_q <= 4'h0;
      syn2_q <= 4'h0;
      syn3_q <= 4'h0;
    end else begin
      syn1_q <= {dbgReq, jtagTdi, jtagTms, jtagTck};
      syn2_q <= syn1_q;
      syn3_q <= syn2_q;
    end
  end

  assign tckRise = syn2_q[0] & ~syn3_q[0];
  assign tmsRise = syn2_q[1] & ~syn3_q[1];
  assign tmsFall = ~syn2_q[1] & syn3_q[1];
  assign jtExec  = tmsFall;
  assign jtOp    = jsr_q[JT_LEN-1 -: 8];
  assign jtMem   = jtExec && (jtOp >= OP_WRMEM) && (jtOp <= OP_RDREG);

  // apb: zero wait state, read data latched in setup phase
  assign rdSetup = psel & ~penable & ~pwrite;
  assign wrAcc   = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);

  // trigger evaluation; in range mode trigger 0 carries config and actions
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      hitOne[i] = trig_hit(tCfg_q[i], dAddr == tAddr_q[i], dData == tData_q[i]);
    end
    hitRange = trig_hit(tCfg_q[0], (dAddr >= tAddr_q[0]) && (dAddr <= tAddr_q[1]),
                        (dData >= tData_q[0]) && (dData <= tData_q[1]));
    fire     = ctrl_q[CTRL_RANGE] ? {1'b0, hitRange} : hitOne;
    actHalt  = 1'b0;
    actTrace = 1'b0;
    actOut   = 1'b0;
    for (int i = 0; i < 2; i++) begin
      actHalt  = actHalt | (fire[i] & tCfg_q[i][CFG_HALT]);
      actTrace = actTrace | (fire[i] & tCfg_q[i][CFG_TRACE]);
      actOut   = actOut | (fire[i] & tCfg_q[i][CFG_OUT]);
    end
  end

  // halt sources; any set wins over a resume in the same cycle
  assign bpHit   = ctrl_q[CTRL_HWBP] & instValid & (instAddr == hwBp_q);
  assign haltSet = (wrAcc && paddr == ADDR_CTRL && pwdata[CTRL_HALT])
                 | (jtExec && jtOp == OP_HALT) | swBreak | bpHit | actHalt;
  assign haltClr = (wrAcc && paddr == ADDR_CTRL && pwdata[CTRL_RESUME]) | (jtExec && jtOp == OP_RESUME);
  assign statClr = (wrAcc && paddr == ADDR_INTCLR) ? pwdata[EV_W-1:0] : '0;
  assign ev      = {traceLoss, |fire, cpuHalted & ~halted_q};

  // control, trigger, memory port and jtag shift next state
  always_comb begin
    ctrl_d     = ctrl_q;
    hwBp_d     = hwBp_q;
    inten_d    = inten_q;
    tIdx_d     = tIdx_q;
    tAddr_d    = tAddr_q;
    tData_d    = tData_q;
    tCfg_d     = tCfg_q;
    memReq_d   = memReq_q;
    memWrite_d = memWrite_q;
    memSpace_d = memSpace_q;
    memAddr_d  = memAddr_q;
    memWdata_d = memWdata_q;
    memRd_d    = memRd_q;
    jsr_d      = jsr_q;
    halt_d     = haltSet | (halt_q & ~haltClr);
    stat_d     = ev | (stat_q & ~statClr);
    trigOut_d  = actOut;
    if (wrAcc && paddr[7:5] == TRIG_SEL) begin
      case (paddr[3:2])
        TW_ADDR: tAddr_d[paddr[4]] = pwdata;
        TW_DATA: tData_d[paddr[4]] = pwdata;
        TW_CFG:  tCfg_d[paddr[4]] = pwdata[CFG_W-1:0];
        default: ;
      endcase
    end else if (wrAcc) begin
      case (paddr)
        ADDR_CTRL:  ctrl_d = pwdata[CTRL_W-1:0] & CTRL_KEEP;
        ADDR_INTEN: inten_d = pwdata[EV_W-1:0];
        ADDR_HWBP:  hwBp_d = pwdata;
        ADDR_TIDX:  tIdx_d = pwdata[TIW-1:0];
        ADDR_MADDR: if (!memReq_q) memAddr_d = pwdata;
        ADDR_MDATA: if (!memReq_q) memWdata_d = pwdata;
        default: ;
      endcase
    end
    if (actTrace) begin
      ctrl_d[CTRL_TRACE] = 1'b1;
    end
    // one access in flight; address steps after each for download
    if (memReq_q && memAck) begin
      memReq_d  = 1'b0;
      memAddr_d = memAddr_q + MEM_STEP;
      if (!memWrite_q) begin
        memRd_d = memRdata;
      end
    end else if (!memReq_q && jtMem) begin
      memReq_d   = 1'b1;
      memWrite_d = ~jtOp[0];
      memSpace_d = jtOp[1];
      memWdata_d = jsr_q[31:0];
    end else if (!memReq_q && jtExec && jtOp == OP_SETADDR) begin
      memAddr_d = jsr_q[31:0];
    end else if (!memReq_q && wrAcc && paddr == ADDR_MCMD) begin
      memReq_d   = 1'b1;
      memWrite_d = pwdata[MCMD_WRITE];
      memSpace_d = pwdata[MCMD_SPACE];
    end
    // frame start loads last read data for the host to shift out
    if (tmsRise) begin
      jsr_d = {8'h00, memRd_q};
    end else if (syn2_q[1] && tckRise) begin
      jsr_d = {syn2_q[2], jsr_q[JT_LEN-1:1]};
    end
  end

  // register read mux
  always_comb begin
    rdata = '0;
    tEnt  = tbuf_q[tIdx_q];
    if (paddr[7:5] == TRIG_SEL) begin
      case (paddr[3:2])
        TW_ADDR: rdata = tAddr_q[paddr[4]];
        TW_DATA: rdata = tData_q[paddr[4]];
        TW_CFG:  rdata[CFG_W-1:0] = tCfg_q[paddr[4]];
        default: ;
      endcase
    end else begin
      case (paddr)
        ADDR_CTRL: begin
          rdata[CTRL_W-1:0]  = ctrl_q;
          rdata[CTRL_HALTED] = cpuHalted;
        end
        ADDR_STAT:   rdata[EV_W-1:0] = stat_q;
        ADDR_INTEN:  rdata[EV_W-1:0] = inten_q;
        ADDR_HWBP:   rdata = hwBp_q;
        ADDR_MADDR:  rdata = memAddr_q;
        ADDR_MDATA:  rdata = memRd_q;
        ADDR_MCMD:   rdata[MCMD_BUSY] = memReq_q;
        ADDR_TIDX:   rdata[TIW-1:0] = tIdx_q;
        ADDR_TINFO: begin
          rdata[TINFO_WP +: TIW] = wp_q;
          rdata[2:0]             = tEnt[TF_W-1 -: 3];
        end
        ADDR_TIADDR: rdata = tEnt[TF_IADDR +: 32];
        ADDR_TDADDR: rdata = tEnt[TF_DADDR +: 32];
        ADDR_TDDATA: rdata = tEnt[TF_DDATA +: 32];
        default: ;
      endcase
    end
    prdata_d = rdSetup ? rdata : prdata_q;
  end

  // trace capture; trigger cycle itself is already recorded
  assign frame    = {instValid, dValid, dWrite, instAddr, dAddr, dData};
  assign traceHit = (ctrl_q[CTRL_TRACE] | actTrace) & (instValid | dValid);
  always_comb begin
    wp_d          = wp_q;
    tWe           = 1'b0;
    traceLoss     = 1'b0;
    traceClk_d    = ~traceClk_q;
    traceFrame_d  = traceFrame_q;
    traceStrobe_d = traceStrobe_q;
    if (ctrl_q[CTRL_OFFCHIP]) begin
      // outputs change only with a rising trace clock; a frame in the high phase is lost
      if (!traceClk_q) begin
        traceStrobe_d = traceHit;
        if (traceHit) begin
          traceFrame_d = frame;
        end
      end else begin
        traceLoss = traceHit;
      end
    end else begin
      traceStrobe_d = traceStrobe_q & traceClk_q;
      if (traceHit) begin
        tWe       = 1'b1;
        traceLoss = (wp_q == TIW'(TRACE_FRAMES - 1));
        wp_d      = traceLoss ? '0 : wp_q + 1'b1;
      end
    end
  end

  // trace storage, addressed by write pointer
  always_ff @(posedge clk_sys) begin
    if (tWe) begin
      tbuf_q[wp_q] <= frame;
    end
  end

  // all control state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      halt_q        <= 1'b0;
      halted_q      <= 1'b0;
      ctrl_q        <= CTRL_RST;
      hwBp_q        <= '0;
      inten_q       <= '0;
      stat_q        <= '0;
      tIdx_q        <= '0;
      tAddr_q       <= '{default: '0};
      tData_q       <= '{default: '0};
      tCfg_q        <= '{default: '0};
      memReq_q      <= 1'b0;
      memWrite_q    <= 1'b0;
      memSpace_q    <= 1'b0;
      memAddr_q     <= '0;
      memWdata_q    <= '0;
      memRd_q       <= '0;
      jsr_q         <= '0;
      tdo_q         <= 1'b0;
      trigOut_q     <= 1'b0;
      prdata_q      <= '0;
      wp_q          <= '0;
      traceClk_q    <= 1'b0;
      traceFrame_q  <= '0;
      traceStrobe_q <= 1'b0;
    end else begin
      halt_q        <= halt_d;
      halted_q      <= cpuHalted;
      ctrl_q        <= ctrl_d;
      hwBp_q        <= hwBp_d;
      inten_q       <= inten_d;
      stat_q        <= stat_d;
      tIdx_q        <= tIdx_d;
      tAddr_q       <= tAddr_d;
      tData_q       <= tData_d;
      tCfg_q        <= tCfg_d;
      memReq_q      <= memReq_d;
      memWrite_q    <= memWrite_d;
      memSpace_q    <= memSpace_d;
      memAddr_q     <= memAddr_d;
      memWdata_q    <= memWdata_d;
      memRd_q       <= memRd_d;
      jsr_q         <= jsr_d;
      tdo_q         <= jsr_d[0];
      trigOut_q     <= trigOut_d;
      prdata_q      <= prdata_d;
      wp_q          <= wp_d;
      traceClk_q    <= traceClk_d;
      traceFrame_q  <= traceFrame_d;
      traceStrobe_q <= traceStrobe_d;
    end
  end

  // outputs; ack follows halted state and the synced request
  assign cpuHaltReq    = halt_q | syn2_q[3];
  assign dbgAck        = syn2_q[3] & cpuHalted;
  assign irq           = |(stat_q & inten_q);
  assign prdata        = prdata_q;
  assign jtagTdo       = tdo_q;
  assign memReq        = memReq_q;
  assign memWrite      = memWrite_q;
  assign memSpace      = memSpace_q;
  assign memAddr       = memAddr_q;
  assign memWdata      = memWdata_q;
  assign trigOut       = trigOut_q;
  assign traceClkOut   = traceClk_q;
  assign traceStrobe   = traceStrobe_q;
  assign traceFrameOut = traceFrame_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_jt_halt;
    jtExec && jtOp == OP_HALT |=> cpuHaltReq;
  endproperty
  a_jt_halt: assert property (p_jt_halt) else $error("jtag halt not applied");
  property p_download;
    jtExec && !memReq_q && jtOp == OP_WRMEM |=> memReq && memWrite && memWdata == $past(jsr_q[31:0]);
  endproperty
  a_download: assert property (p_download) else $error("download write not issued");
  property p_sw_break;
    swBreak |=> cpuHaltReq;
  endproperty
  a_sw_break: assert property (p_sw_break) else $error("software break did not halt");
  property p_hw_break;
    ctrl_q[CTRL_HWBP] && instValid && instAddr == hwBp_q && !syn2_q[3] |=> halt_q && cpuHaltReq;
  endproperty
  a_hw_break: assert property (p_hw_break) else $error("hardware break did not halt");
  property p_range;
    ctrl_q[CTRL_RANGE] && dValid && (dWrite ? tCfg_q[0][CFG_WR] : tCfg_q[0][CFG_RD]) && tCfg_q[0][CFG_ADDR]
      && !tCfg_q[0][CFG_DATA] && tCfg_q[0][CFG_OUT] && dAddr >= tAddr_q[0] && dAddr <= tAddr_q[1]
      |=> trigOut && stat_q[EV_TRIG];
  endproperty
  a_range: assert property (p_range) else $error("range trigger missed");
  property p_trace_onchip;
    traceHit && !ctrl_q[CTRL_OFFCHIP] |=> tbuf_q[$past(wp_q)] == $past(frame);
  endproperty
  a_trace_onchip: assert property (p_trace_onchip) else $error("trace frame not stored");
  property p_offchip;
    $changed(traceFrameOut) |-> traceClkOut ##1 $stable(traceFrameOut);
  endproperty
  a_offchip: assert property (p_offchip) else $error("trace output not aligned to trace clock");
  property p_ack;
    dbgReq [*3] ##0 cpuHalted |-> dbgAck;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge missing while halted");
  property p_ack_drop;
    !dbgReq [*3] |-> !dbgAck;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("acknowledge held after request removed");
  property p_depth;
    1'b1 |-> TRACE_FRAMES >= TRACE_MIN && TRACE_FRAMES <= TRACE_MAX;
  endproperty
  a_depth: assert property (p_depth) else $error("trace depth out of range");

  c_halt: cover property (cpuHaltReq ##[1:20] cpuHalted);
  c_trig: cover property (trigOut);
  c_wrap: cover property (traceLoss && !ctrl_q[CTRL_OFFCHIP]);
  c_ack: cover property (dbgAck);
endmodule : dbm_debug_module

// [pkg/dbm_pkg.sv]
package dbm_pkg;
  // apb map, byte addresses
  localparam int         APB_AW      = 8;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STAT   = 8'h04;
  localparam logic [7:0] ADDR_INTEN  = 8'h08;
  localparam logic [7:0] ADDR_INTCLR = 8'h0c;
  localparam logic [7:0] ADDR_HWBP   = 8'h10;
  localparam logic [7:0] ADDR_MADDR  = 8'h14;
  localparam logic [7:0] ADDR_MDATA  = 8'h18;
  localparam logic [7:0] ADDR_MCMD   = 8'h1c;
  localparam logic [7:0] ADDR_TIDX   = 8'h20;
  localparam logic [7:0] ADDR_TINFO  = 8'h24;
  localparam logic [7:0] ADDR_TIADDR = 8'h28;
  localparam logic [7:0] ADDR_TDADDR = 8'h2c;
  localparam logic [7:0] ADDR_TDDATA = 8'h30;
  // triggers at 0x40 + 0x10*i: addr +0, data +4, cfg +8
  localparam logic [2:0] TRIG_SEL    = 3'h2;
  localparam logic [1:0] TW_ADDR     = 2'h0;
  localparam logic [1:0] TW_DATA     = 2'h1;
  localparam logic [1:0] TW_CFG      = 2'h2;
  // control fields
  localparam int         CTRL_W      = 6;
  localparam int         CTRL_HALT   = 0;
  localparam int         CTRL_RESUME = 1;
  localparam int         CTRL_TRACE  = 2;
  localparam int         CTRL_OFFCHIP = 3;
  localparam int         CTRL_RANGE  = 4;
  localparam int         CTRL_HWBP   = 5;
  localparam int         CTRL_HALTED = 8;
  localparam logic [5:0] CTRL_KEEP   = 6'h3c;
  localparam logic [5:0] CTRL_RST    = 6'h00;
  // trigger config fields
  localparam int         CFG_W       = 7;
  localparam int         CFG_ADDR    = 0;
  localparam int         CFG_DATA    = 1;
  localparam int         CFG_RD      = 2;
  localparam int         CFG_WR      = 3;
  localparam int         CFG_HALT    = 4;
  localparam int         CFG_TRACE   = 5;
  localparam int         CFG_OUT     = 6;
  // event bits of status, enable and clear
  localparam int         EV_W        = 3;
  localparam int         EV_HALT     = 0;
  localparam int         EV_TRIG     = 1;
  localparam int         EV_LOSS     = 2;
  // memory command fields
  localparam int         MCMD_WRITE  = 0;
  localparam int         MCMD_SPACE  = 1;
  localparam int         MCMD_BUSY   = 2;
  localparam logic [31:0] MEM_STEP   = 32'h0000_0004;
  // jtag frame: data in bits 31:0, op in 39:32, lsb first
  localparam int         JT_LEN      = 40;
  localparam logic [7:0] OP_HALT     = 8'h01;
  localparam logic [7:0] OP_RESUME   = 8'h02;
  localparam logic [7:0] OP_SETADDR  = 8'h03;
  localparam logic [7:0] OP_WRMEM    = 8'h04;
  localparam logic [7:0] OP_RDREG    = 8'h07;
  // trace frame {iv, dv, dw, iaddr, daddr, ddata}
  localparam int         TF_W        = 99;
  localparam int         TF_DDATA    = 0;
  localparam int         TF_DADDR    = 32;
  localparam int         TF_IADDR    = 64;
  localparam int         TINFO_WP    = 16;
  localparam int         TRACE_DEPTH = 128;
  localparam int         TRACE_MIN   = 128;
  localparam int         TRACE_MAX   = 65536;
endpackage : dbm_pkg

// [sim/dbm_cpu_model.sv]
`timescale 1ns/10ps
module dbm_cpu_model #(
  parameter int ACK_DLY = 3
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        cpuHaltReq,
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  output logic             cpuHalted,
  output logic             memAck,
  output logic      [31:0] memRdata
);
  logic [1:0] haltPipe_q;
  int         waitCnt_q;

  // processor side: stops two cycles late, answers memory slowly
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      haltPipe_q <= '0;
      waitCnt_q  <= 0;
      memAck     <= 1'b0;
      memRdata   <= '0;
    end else begin
      haltPipe_q <= {haltPipe_q[0], cpuHaltReq};
      memAck     <= 1'b0;
      memRdata   <= ~memRdata; // released data never holds its old value
      if (memReq && !memAck) begin
        waitCnt_q <= waitCnt_q + 1;
        if (waitCnt_q == ACK_DLY) begin
          memAck    <= 1'b1;
          memRdata  <= memAddr ^ 32'h5a5a_5a5a;
          waitCnt_q <= 0;
        end
      end
    end
  end

  assign cpuHalted = haltPipe_q[1];
endmodule : dbm_cpu_model

// [sim/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import dbm_pkg::*;
  logic clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, jtagTck = 0, jtagTms = 0, jtagTdi = 0;
  logic swBreak = 0, instValid = 0, dValid = 0, dWrite = 0, dbgReq = 0, err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, instAddr = '0, dAddr = '0, dData = '0, memRdata, memAddr, memWdata, prdata, rd, jrd;
  logic pready, pslverr, jtagTdo, cpuHaltReq, cpuHalted, memReq, memWrite, memSpace, memAck, trigOut;
  logic traceClkOut, traceStrobe, dbgAck, irq;
  logic [TF_W-1:0] traceFrameOut;
  int failures = 0, cmp_count = 0, cycles = 0;
  localparam logic [31:0] PAT = 32'h5a5a_5a5a;

  always #10 clk_sys = ~clk_sys;

  dbm_debug_module #(.TRACE_FRAMES(TRACE_MIN)) i_dbm_debug_module (.*);
  dbm_cpu_model i_dbm_cpu_model (.*);

  // hang guard, well above the roughly 1550 cycles needed
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait, sampled just after the edge so design updates have landed
  task automatic wait_lvl(ref logic s, input logic v, input int n);
    int k;
    k = 0;
    while (s !== v && k < n) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk({31'h0, s}, {31'h0, v});
  endtask : wait_lvl

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk

  // tck is held still outside frames; 160 ns period inside
  task jtag(input logic [7:0] op, input logic [31:0] d);
    logic [39:0] f;
    f = {op, d};
    @(posedge clk_sys) jtagTms <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < JT_LEN; i++) begin
      jtagTdi <= f[i];
      repeat (4) @(posedge clk_sys);
      // tdo has settled from the previous shift by now
      if (i < 32) jrd[i] = jtagTdo;
      jtagTck <= 1'b1;
      repeat (4) @(posedge clk_sys);
      jtagTck <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    jtagTms <= 1'b0;
    jtagTdi <= ~f[39];
    // keep tms low long enough before any next frame
    repeat (4) @(posedge clk_sys);
  endtask : jtag

  task inst(input logic [31:0] a);
    @(posedge clk_sys) instValid <= 1'b1;
    instAddr <= a;
    @(posedge clk_sys) instValid <= 1'b0;
    #1;
  endtask : inst

  task dat(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys) dValid <= 1'b1;
    dWrite <= w;
    dAddr <= a;
    dData <= d;
    @(posedge clk_sys) dValid <= 1'b0;
    #1;
  endtask : dat

  task t_regs;
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_STAT, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h3c);
    rdchk(ADDR_CTRL, {26'h0, CTRL_KEEP});
    apb(1'b1, ADDR_CTRL, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task t_halt;
    apb(1'b1, ADDR_INTEN, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_HALT);
    wait_lvl(cpuHaltReq, 1'b1, 4);
    wait_lvl(irq, 1'b1, 8);
    rdchk(ADDR_CTRL, 32'h1 << CTRL_HALTED);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_RESUME);
    wait_lvl(cpuHalted, 1'b0, 8);
    apb(1'b1, ADDR_INTCLR, 32'h1);
    wait_lvl(irq, 1'b0, 2);
    $display("test halt done");
  endtask : t_halt

  task t_mem;
    jtag(OP_SETADDR, 32'h100);
    jtag(OP_WRMEM, 32'h1234_abcd);
    wait_lvl(memReq, 1'b1, 8);
    chk(memAddr, 32'h100);
    chk(memWdata, 32'h1234_abcd);
    chk({30'h0, memWrite, memSpace}, 32'h2);
    jtag(OP_WRMEM, 32'h5678_9abc);
    wait_lvl(memReq, 1'b1, 8);
    chk(memAddr, 32'h100 + MEM_STEP);
    wait_lvl(memReq, 1'b0, 8);
    apb(1'b1, ADDR_MADDR, 32'h200);
    apb(1'b1, ADDR_MCMD, 32'h0);
    wait_lvl(memReq, 1'b1, 4);
    chk(memAddr, 32'h200);
    wait_lvl(memAck, 1'b1, 8);
    apb(1'b0, ADDR_MCMD, 32'h0);
    chk({31'h0, rd[MCMD_BUSY]}, 32'h0);
    rdchk(ADDR_MDATA, 32'h200 ^ PAT);
    jtag(8'h00, 32'h0);
    chk(jrd, 32'h200 ^ PAT);
    apb(1'b1, ADDR_MCMD, 32'h3);
    wait_lvl(memReq, 1'b1, 4);
    chk({30'h0, memWrite, memSpace}, 32'h3);
    $display("test mem done");
  endtask : t_mem

  task t_bp;
    @(posedge clk_sys) swBreak <= 1'b1;
    @(posedge clk_sys) swBreak <= 1'b0;
    wait_lvl(cpuHaltReq, 1'b1, 4);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_RESUME);
    wait_lvl(cpuHalted, 1'b0, 8);
    apb(1'b1, ADDR_HWBP, 32'h400);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_HWBP);
    inst(32'h3fc);
    @(posedge clk_sys);
    #1;
    chk({31'h0, cpuHaltReq}, 32'h0);
    inst(32'h400);
    wait_lvl(cpuHaltReq, 1'b1, 4);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_RESUME);
    wait_lvl(cpuHalted, 1'b0, 8);
    $display("test breakpoints done");
  endtask : t_bp

  task t_dbg;
    @(posedge clk_sys) dbgReq <= 1'b1;
    wait_lvl(dbgAck, 1'b1, 10);
    chk({31'h0, cpuHalted}, 32'h1);
    @(posedge clk_sys) dbgReq <= 1'b0;
    wait_lvl(dbgAck, 1'b0, 4);
    wait_lvl(cpuHalted, 1'b0, 8);
    $display("test debug request done");
  endtask : t_dbg

  task t_trig;
    apb(1'b1, 8'h40, 32'h800);
    apb(1'b1, 8'h48, 32'h49);
    dat(1'b0, 32'h800, 32'h0);
    chk({31'h0, trigOut}, 32'h0);
    dat(1'b1, 32'h800, 32'h0);
    chk({31'h0, trigOut}, 32'h1);
    @(posedge clk_sys);
    #1;
    chk({31'h0, trigOut}, 32'h0);
    apb(1'b1, 8'h44, 32'hcafe);
    apb(1'b1, 8'h48, 32'h4a);
    dat(1'b1, 32'h0, 32'hcafe);
    chk({31'h0, trigOut}, 32'h1);
    apb(1'b1, 8'h48, 32'h49);
    apb(1'b1, 8'h50, 32'h8ff);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_RANGE);
    dat(1'b1, 32'h880, 32'h0);
    chk({31'h0, trigOut}, 32'h1);
    dat(1'b1, 32'h900, 32'h0);
    chk({31'h0, trigOut}, 32'h0);
    apb(1'b1, 8'h48, 32'h19);
    dat(1'b1, 32'h8ff, 32'h0);
    wait_lvl(cpuHaltReq, 1'b1, 4);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_RESUME);
    wait_lvl(cpuHalted, 1'b0, 8);
    $display("test triggers done");
  endtask : t_trig

  task t_trace;
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_TRACE);
    inst(32'h10);
    inst(32'h14);
    dat(1'b1, 32'h20, 32'h33);
    apb(1'b0, ADDR_TINFO, 32'h0);
    chk({16'h0, rd[31:16]}, 32'h3);
    apb(1'b1, ADDR_TIDX, 32'h0);
    rdchk(ADDR_TIADDR, 32'h10);
    apb(1'b1, ADDR_TIDX, 32'h2);
    rdchk(ADDR_TDADDR, 32'h20);
    rdchk(ADDR_TDDATA, 32'h33);
    apb(1'b1, ADDR_CTRL, 32'hc);
    // launch the frame so it lands in the low trace clock phase
    @(posedge clk_sys iff !traceClkOut);
    inst(32'h30);
    wait_lvl(traceStrobe, 1'b1, 6);
    chk({31'h0, traceClkOut}, 32'h1);
    chk(traceFrameOut[TF_IADDR+:32], 32'h30);
    $display("test trace done");
  endtask : t_trace

  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_halt();
    t_mem();
    t_bp();
    t_dbg();
    t_trig();
    t_trace();
    test_done();
  end
endmodule : tb_top
